// file: rtl/ifd_consts.svh
`ifndef IFD_CONSTS_SVH
`define IFD_CONSTS_SVH

// register byte offsets
`define IFD_OFF_INSN 6'h00
`define IFD_OFF_CTRL 6'h04
`define IFD_OFF_DEC 6'h08
`define IFD_OFF_CFG 6'h0c
`define IFD_OFF_STAT 6'h10
`define IFD_OFF_MASK 6'h14
`define IFD_OFF_IMM 6'h18

// reset values
`define IFD_RST_CFG 4'h0
`define IFD_RST_MASK 2'h0
`define IFD_RST_FLAGS 5'h00

// status bit positions
`define IFD_ST_TRAP 0
`define IFD_ST_DONE 1

// selector codes
`define IFD_AREG_STACK 4'h0
`define IFD_AREG_FRAME 4'h8
`define IFD_AREG_CUR_SP 4'h9
`define IFD_AREG_STATIC 4'ha
`define IFD_AREG_INTTAB 4'he
`define IFD_AREG_UNITD 4'hf

`endif

// file: rtl/ifd_pkg.sv
package ifd_pkg;

    typedef enum logic [3:0] {
        IFD_FMT_NONE,
        IFD_FMT_CTRL1,
        IFD_FMT_QUICK2,
        IFD_FMT_ONE3,
        IFD_FMT_STR5,
        IFD_FMT_FLT9,
        IFD_FMT_MMU14,
        IFD_FMT_MOV8,
        IFD_FMT_CUST15
    } ifd_fmt_t;

    typedef struct packed {
        logic z;
        logic c;
        logic l;
        logic n;
        logic f;
    } ifd_flags_t;

    typedef struct packed {
        logic cond_true;
        logic undefined_opcode_trap;
        logic [3:0] reg_sel;
        logic reg_valid;
        logic [1:0] match_mode;
        logic backward;
        logic translate;
        logic long_operand;
        logic [3:0] config_bits;
        logic config_write;
        logic [31:0] quick_imm;
    } ifd_dec_t;

    typedef enum logic [1:0] {
        IFD_IDLE,
        IFD_WRESP,
        IFD_RRESP
    } ifd_state_t;

endpackage

// file: rtl/ifd_decoder.sv
`timescale 1ns/1ps
`include "ifd_consts.svh"

module ifd_decoder
    import ifd_pkg::*;
#(
    parameter int ADDR_W = 6
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq
);

    // the register decode compares six address bits
    if (ADDR_W < 6) begin : g_bad_addr_w
        $error("ADDR_W too small for register map");
    end

    // ==========================================================
    // register state
    // ==========================================================
    logic [23:0] insn;
    logic [3:0] fmt_sel;
    ifd_flags_t flags;
    logic [3:0] cfg;
    logic [1:0] stat;
    logic [1:0] mask;
    ifd_dec_t dec;
    ifd_state_t state;
    logic [ADDR_W-1:0] aw_q;
    logic [31:0] w_q;
    logic [3:0] ws_q;
    logic aw_got;
    logic w_got;
    logic [31:0] rdata;
    logic [1:0] resp;
    logic [23:0] next_insn;
    logic [3:0] next_fmt_sel;
    ifd_flags_t next_flags;
    logic [3:0] next_cfg;
    logic [1:0] next_stat;
    logic [1:0] next_mask;
    ifd_dec_t next_dec;
    ifd_state_t next_state;
    logic [ADDR_W-1:0] next_aw_q;
    logic [31:0] next_w_q;
    logic [3:0] next_ws_q;
    logic next_aw_got;
    logic next_w_got;
    logic [31:0] next_rdata;
    logic [1:0] next_resp;
    logic wr_fire;
    logic rd_fire;
    logic wr_known;
    logic rd_known;
    logic decode_go;
    ifd_dec_t comb_dec;
    logic decode_pend;

    // ==========================================================
    // combinational decode of the latched instruction
    // ==========================================================
    always_comb begin
        logic [3:0] cd;
        logic [3:0] op4;
        logic [2:0] op3;
        logic [3:0] sh;
        cd = insn[10:7];
        sh = insn[10:7];
        op4 = insn[7:4];
        op3 = insn[13:11];
        comb_dec = '0;
        // condition evaluation
        case (cd)
            4'h0: comb_dec.cond_true = flags.z;
            4'h1: comb_dec.cond_true = ~flags.z;
            4'h2: comb_dec.cond_true = flags.c;
            4'h3: comb_dec.cond_true = ~flags.c;
            4'h4: comb_dec.cond_true = flags.l;
            4'h5: comb_dec.cond_true = ~flags.l;
            4'h6: comb_dec.cond_true = flags.n;
            4'h7: comb_dec.cond_true = ~flags.n;
            4'h8: comb_dec.cond_true = flags.f;
            4'h9: comb_dec.cond_true = ~flags.f;
            4'ha: comb_dec.cond_true = ~flags.l & ~flags.z;
            4'hb: comb_dec.cond_true = flags.l | flags.z;
            4'hc: comb_dec.cond_true = ~flags.n & ~flags.z;
            4'hd: comb_dec.cond_true = flags.n | flags.z;
            4'he: comb_dec.cond_true = 1'b1;
            default: comb_dec.cond_true = 1'b0;
        endcase
        // quick immediate, sign extended to full word
        comb_dec.quick_imm = {{28{sh[3]}}, sh};
        comb_dec.long_operand = insn[10];
        case (ifd_fmt_t'(fmt_sel))
            IFD_FMT_CTRL1: begin
                // 0 call, a no-op, e svc, f bpt; all 16 defined
                comb_dec.reg_sel = insn[7:4];
                comb_dec.reg_valid = 1'b1;
            end
            IFD_FMT_QUICK2: begin
                comb_dec.reg_sel = sh;
                // only dedicated load/store use the selector
                if (insn[6:4] == 3'b110 || insn[6:4] == 3'b010) begin
                    case (sh)
                        `IFD_AREG_STACK, `IFD_AREG_FRAME,
                        `IFD_AREG_CUR_SP, `IFD_AREG_STATIC,
                        `IFD_AREG_INTTAB, `IFD_AREG_UNITD:
                            comb_dec.reg_valid = 1'b1;
                        default: begin
                            comb_dec.undefined_opcode_trap = 1'b1;
                        end
                    endcase
                end
            end
            IFD_FMT_ONE3: begin
                op4 = insn[10:7];
                if (op4[0] || op4 == 4'h8) begin
                    comb_dec.undefined_opcode_trap = 1'b1;
                end
            end
            IFD_FMT_STR5: begin
                op4 = insn[13:10];
                if (op4[3] || op4[3:2] == 2'b01) begin
                    comb_dec.undefined_opcode_trap = 1'b1;
                end else if (op4 == 4'h2) begin
                    comb_dec.config_bits = insn[18:15];
                    comb_dec.config_write = 1'b1;
                end else begin
                    comb_dec.translate = insn[15];
                    comb_dec.backward = insn[16];
                    comb_dec.match_mode = insn[18:17];
                    if (insn[18:17] == 2'b10) begin
                        comb_dec.undefined_opcode_trap = 1'b1;
                    end
                end
            end
            IFD_FMT_MMU14: begin
                op4 = insn[13:10];
                sh = insn[18:15];
                comb_dec.reg_sel = sh;
                if (op4[3] || op4[3:2] == 2'b01) begin
                    comb_dec.undefined_opcode_trap = 1'b1;
                end else if (op4[1]) begin
                    case (sh)
                        4'h2, 4'h3, 4'h6, 4'h7, 4'h9, 4'he:
                            comb_dec.undefined_opcode_trap = 1'b1;
                        default: comb_dec.reg_valid = 1'b1;
                    endcase
                end
            end
            IFD_FMT_MOV8: begin
                // shared opcode 1 10; reg picks direction
                comb_dec.reg_sel = {1'b0, insn[18:16]};
                if (insn[18:16] == 3'b001 || insn[18:16] == 3'b011) begin
                    comb_dec.reg_valid = 1'b1;
                end else begin
                    comb_dec.undefined_opcode_trap = 1'b1;
                end
            end
            IFD_FMT_FLT9: begin
                comb_dec.reg_sel = {1'b0, op3};
                comb_dec.reg_valid = 1'b1;
            end
            IFD_FMT_CUST15: begin
                op4 = insn[13:10];
                comb_dec.reg_sel = op4;
                if (insn[7:5] != 3'b000 || op4[3:2] != 2'b00) begin
                    comb_dec.undefined_opcode_trap = 1'b1;
                end else begin
                    comb_dec.reg_valid = 1'b1;
                end
            end
            default: begin
                comb_dec.undefined_opcode_trap = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // axi4-lite slave
    // ==========================================================
    assign s_axi_awready = (state == IFD_IDLE) && !aw_got;
    assign s_axi_wready = (state == IFD_IDLE) && !w_got;
    assign s_axi_arready = (state == IFD_IDLE) && !aw_got && !w_got;
    assign s_axi_bvalid = (state == IFD_WRESP);
    assign s_axi_rvalid = (state == IFD_RRESP);
    assign s_axi_bresp = resp;
    assign s_axi_rresp = resp;
    assign s_axi_rdata = rdata;
    assign irq = |(stat & mask);

    always_comb begin
        logic [ADDR_W-1:0] wa;
        logic [31:0] wd;
        wa = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : aw_q;
        wd = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : w_q;
        next_insn = insn;
        next_fmt_sel = fmt_sel;
        next_flags = flags;
        next_cfg = cfg;
        next_stat = stat;
        next_mask = mask;
        next_dec = dec;
        next_state = state;
        next_aw_q = aw_q;
        next_w_q = w_q;
        next_ws_q = ws_q;
        next_aw_got = aw_got;
        next_w_got = w_got;
        next_rdata = rdata;
        next_resp = resp;
        decode_go = 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_q = s_axi_awaddr;
            next_aw_got = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_q = s_axi_wdata;
            next_ws_q = s_axi_wstrb;
            next_w_got = 1'b1;
        end
        wr_fire = next_aw_got && next_w_got && (state == IFD_IDLE);
        rd_fire = s_axi_arvalid && s_axi_arready;
        wr_known = (wa[ADDR_W-1:2] <= 4'h6) && (wa[1:0] == 2'b00);
        rd_known = (s_axi_araddr[ADDR_W-1:2] <= 4'h6)
            && (s_axi_araddr[1:0] == 2'b00);
        if (wr_fire) begin
            next_aw_got = 1'b0;
            next_w_got = 1'b0;
            next_state = IFD_WRESP;
            next_resp = wr_known ? 2'b00 : 2'b10;
            case (wa[5:0])
                `IFD_OFF_INSN: begin
                    next_insn = wd[23:0];
                    decode_go = 1'b1;
                end
                `IFD_OFF_CTRL: begin
                    next_fmt_sel = wd[3:0];
                    next_flags = wd[8:4];
                end
                `IFD_OFF_CFG: next_cfg = wd[3:0];
                `IFD_OFF_MASK: next_mask = wd[1:0];
                default: next_resp = wr_known ? 2'b00 : 2'b10;
            endcase
        end else if (rd_fire) begin
            next_state = IFD_RRESP;
            next_resp = rd_known ? 2'b00 : 2'b10;
            case (s_axi_araddr[5:0])
                `IFD_OFF_INSN: next_rdata = {8'h00, insn};
                `IFD_OFF_CTRL: next_rdata = {23'h000000, flags, fmt_sel};
                `IFD_OFF_DEC: next_rdata = {15'h0000, dec[48:32]};
                `IFD_OFF_CFG: next_rdata = {28'h0000000, cfg};
                `IFD_OFF_STAT: begin
                    next_rdata = {30'h00000000, stat};
                    next_stat = 2'b00;
                end
                `IFD_OFF_MASK: next_rdata = {30'h00000000, mask};
                `IFD_OFF_IMM: next_rdata = dec.quick_imm;
                default: next_rdata = 32'h00000000;
            endcase
        end
        // set wins over the read-clear in the same cycle
        if (decode_pend) begin
            next_dec = comb_dec;
            next_stat = next_stat | {1'b1, comb_dec.undefined_opcode_trap};
            if (comb_dec.config_write) begin
                next_cfg = comb_dec.config_bits;
            end
        end
        if (state == IFD_WRESP && s_axi_bready) begin
            next_state = IFD_IDLE;
        end
        if (state == IFD_RRESP && s_axi_rready) begin
            next_state = IFD_IDLE;
        end
    end

    // decode result is captured one cycle after the instruction write
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            insn <= 24'h000000;
            fmt_sel <= 4'h0;
            flags <= `IFD_RST_FLAGS;
            cfg <= `IFD_RST_CFG;
            stat <= 2'h0;
            mask <= `IFD_RST_MASK;
            dec <= '0;
            state <= IFD_IDLE;
            aw_q <= '0;
            w_q <= 32'h00000000;
            ws_q <= 4'h0;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            rdata <= 32'h00000000;
            resp <= 2'h0;
            decode_pend <= 1'b0;
        end else begin
            insn <= next_insn;
            fmt_sel <= next_fmt_sel;
            flags <= next_flags;
            mask <= next_mask;
            state <= next_state;
            aw_q <= next_aw_q;
            w_q <= next_w_q;
            ws_q <= next_ws_q;
            aw_got <= next_aw_got;
            w_got <= next_w_got;
            rdata <= next_rdata;
            resp <= next_resp;
            decode_pend <= decode_go;
            stat <= next_stat;
            cfg <= next_cfg;
            dec <= next_dec;
        end
    end

    // ==========================================================
    // checks
    // ==========================================================
    chk_cond_true: assert property (@(posedge core_clk) disable iff (!rst_n)
        decode_pend && insn[10:7] == 4'he |=> dec.cond_true)
        else $error("cond e not true");
    chk_cond_false: assert property (@(posedge core_clk) disable iff (!rst_n)
        decode_pend && insn[10:7] == 4'hf |=> !dec.cond_true)
        else $error("cond f not false");
    chk_zero_test: assert property (@(posedge core_clk) disable iff (!rst_n)
        decode_pend && insn[10:7] == 4'h0 |=> dec.cond_true == $past(flags.z))
        else $error("zero test wrong");
    chk_one_trap: assert property (@(posedge core_clk) disable iff (!rst_n)
        decode_pend && fmt_sel == 4'd3 && insn[7]
        |=> dec.undefined_opcode_trap && stat[`IFD_ST_TRAP])
        else $error("jump format trap missed");
    chk_str_trap: assert property (@(posedge core_clk) disable iff (!rst_n)
        decode_pend && fmt_sel == 4'd4 && insn[13]
        |=> dec.undefined_opcode_trap)
        else $error("string format trap missed");
    chk_mmu_trap: assert property (@(posedge core_clk) disable iff (!rst_n)
        decode_pend && fmt_sel == 4'd6 && insn[13:12] == 2'b01
        |=> dec.undefined_opcode_trap)
        else $error("translation format trap missed");
    chk_quick_sext: assert property (@(posedge core_clk) disable iff (!rst_n)
        decode_pend |=> dec.quick_imm[31:3] == {29{$past(insn[10])}})
        else $error("quick immediate not extended");
    chk_cust_trap: assert property (@(posedge core_clk) disable iff (!rst_n)
        decode_pend && fmt_sel == 4'd8 && insn[13]
        |=> dec.undefined_opcode_trap)
        else $error("custom trap missed");
    chk_irq_level: assert property (@(posedge core_clk) disable iff (!rst_n)
        decode_pend && mask[`IFD_ST_DONE] |=> irq)
        else $error("irq missed after decode done");
    cov_trap: cover property (@(posedge core_clk) disable iff (!rst_n)
        decode_pend ##1 dec.undefined_opcode_trap);
    cov_cfg: cover property (@(posedge core_clk) disable iff (!rst_n)
        decode_pend && comb_dec.config_write);
    cov_irq: cover property (@(posedge core_clk) disable iff (!rst_n)
        $rose(irq));

endmodule // ifd_decoder

// file: tb/ifd_exc_model.sv
`timescale 1ns/1ps

// ==========================================================
// exception unit stand-in: counts interrupt assertions
// ==========================================================
module ifd_exc_model (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic irq,
    output logic [7:0] irq_events
);
    logic irq_q;

    // a rising level is one exception request; a held level is not new
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
            irq_events <= 8'h00;
        end else begin
            irq_q <= irq;
            if (irq && !irq_q) begin
                irq_events <= irq_events + 8'h01;
            end
        end
    end
endmodule // ifd_exc_model

// file: tb/tb_ifd_decoder.sv
`timescale 1ns/1ps
`include "ifd_consts.svh"

module tb_ifd_decoder
    import ifd_pkg::*;
;
    logic core_clk, rst_n, irq;
    logic [5:0] aw_addr, ar_addr;
    logic [31:0] w_data, r_data, v;
    logic aw_valid, aw_ready, w_valid, w_ready, b_valid, b_ready;
    logic ar_valid, ar_ready, r_valid, r_ready;
    logic [1:0] b_resp, r_resp, r;
    logic [7:0] irq_events, e0;
    ifd_dec_t dv;
    int n_fail, num_checks;

    ifd_decoder i_ifd_decoder (
        .core_clk(core_clk), .rst_n(rst_n),
        .s_axi_awaddr(aw_addr), .s_axi_awvalid(aw_valid),
        .s_axi_awready(aw_ready), .s_axi_wdata(w_data),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(w_valid),
        .s_axi_wready(w_ready), .s_axi_bresp(b_resp),
        .s_axi_bvalid(b_valid), .s_axi_bready(b_ready),
        .s_axi_araddr(ar_addr), .s_axi_arvalid(ar_valid),
        .s_axi_arready(ar_ready), .s_axi_rdata(r_data),
        .s_axi_rresp(r_resp), .s_axi_rvalid(r_valid),
        .s_axi_rready(r_ready), .irq(irq)
    );

    ifd_exc_model i_ifd_exc_model (
        .core_clk(core_clk), .rst_n(rst_n), .irq(irq),
        .irq_events(irq_events)
    );

    // ==========================================================
    // bus tasks
    // ==========================================================
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic axw(input logic [5:0] a, input logic [31:0] d,
                       output logic [1:0] rs);
        rs = 2'bxx;
        @(posedge core_clk);
        aw_addr <= a;
        w_data <= d;
        aw_valid <= 1'b1;
        w_valid <= 1'b1;
        b_ready <= 1'b1;
        forever begin
            @(posedge core_clk);
            if (aw_ready) aw_valid <= 1'b0;
            if (w_ready) w_valid <= 1'b0;
            if (b_valid) begin
                rs = b_resp;
                break;
            end
        end
        b_ready <= 1'b0;
    endtask

    task automatic axr(input logic [5:0] a, output logic [31:0] d,
                       output logic [1:0] rs);
        rs = 2'bxx;
        d = 'x;
        @(posedge core_clk);
        ar_addr <= a;
        ar_valid <= 1'b1;
        r_ready <= 1'b1;
        forever begin
            @(posedge core_clk);
            if (ar_ready) ar_valid <= 1'b0;
            if (r_valid) begin
                d = r_data;
                rs = r_resp;
                break;
            end
        end
        r_ready <= 1'b0;
    endtask

    // decode is ready one edge after the write; three leaves margin
    task automatic dec(input logic [3:0] fmt, input logic [4:0] fl,
                       input logic [23:0] ins);
        axw(`IFD_OFF_CTRL, {23'h0, fl, fmt}, r);
        axw(`IFD_OFF_INSN, {8'h0, ins}, r);
        repeat (3) @(posedge core_clk);
        axr(`IFD_OFF_DEC, v, r);
        dv = {v[16:0], 32'h0};
    endtask

    // flags are {z, c, l, n, f}
    function automatic logic ce(input logic [3:0] c, input logic [4:0] f);
        logic [15:0] t;
        t = {1'b0, 1'b1, f[1] | f[4], ~f[1] & ~f[4], f[2] | f[4],
             ~f[2] & ~f[4], ~f[0], f[0], ~f[1], f[1], ~f[2], f[2],
             ~f[3], f[3], ~f[4], f[4]};
        return t[c];
    endfunction

    task automatic finish_test;
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    initial begin
        repeat (60000) @(posedge core_clk);
        n_fail++;
        finish_test();
    end

    // ==========================================================
    // tests
    // ==========================================================
    initial begin
        {aw_addr, ar_addr, w_data} = '0;
        {aw_valid, w_valid, b_ready, ar_valid, r_ready} = '0;
        rst_n = 1'b0;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        axr(`IFD_OFF_CFG, v, r);
        chk(v, 32'(`IFD_RST_CFG));
        axr(`IFD_OFF_MASK, v, r);
        chk(v, 32'(`IFD_RST_MASK));
        chk(32'(irq), 32'h0);
        axr(6'h1c, v, r);
        chk({v, 30'h0, r}, {32'h0, 30'h0, 2'h2});
        axw(6'h1c, 32'h1, r);
        chk(32'(r), 32'h2);
        for (int f = 0; f < 32; f++) begin
            for (int c = 0; c < 16; c++) begin
                dec(IFD_FMT_QUICK2, 5'(f), {13'h0, 4'(c), 3'b011, 4'hc});
                chk(32'(dv.cond_true), 32'(ce(4'(c), 5'(f))));
            end
        end
        for (int s = 0; s < 16; s += 5) begin
            dec(IFD_FMT_QUICK2, 5'h0, {13'h0, 4'(s + 3), 3'b000, 4'hc});
            axr(`IFD_OFF_IMM, v, r);
            chk(v, {{28{v_sign(4'(s + 3))}}, 4'(s + 3)});
        end
        for (int s = 0; s < 16; s++) begin
            if (s != 13) begin
                dec(IFD_FMT_QUICK2, 5'h0, {13'h0, 4'(s), 3'b110, 4'hc});
                chk(32'(dv.reg_valid), 32'(16'hc701 >> s) & 32'h1);
                chk(32'(dv.undefined_opcode_trap), 32'(~16'hc701 >> s) & 32'h1);
            end
        end
        for (int o = 0; o < 16; o++) begin
            dec(IFD_FMT_ONE3, 5'h0, {13'h0, 4'(o), 7'h7f});
            chk(32'(dv.undefined_opcode_trap), 32'(o[0] | (o == 8)));
            dec(IFD_FMT_STR5, 5'h0, {9'h0, 1'b0, 4'(o), 10'h00e});
            chk(32'(dv.undefined_opcode_trap), 32'(o[3] | (o[3:2] == 1)));
            dec(IFD_FMT_MMU14, 5'h0, {9'h0, 1'b0, 4'(o), 10'h01e});
            chk(32'(dv.undefined_opcode_trap), 32'(o[3] | (o[3:2] == 1)));
            dec(IFD_FMT_MMU14, 5'h0, {5'h0, 4'(o), 1'b0, 4'h2, 10'h01e});
            chk(32'(dv.undefined_opcode_trap), 32'(16'h42cc >> o) & 32'h1);
            if (o[3:2] != 2'b10) begin
                dec(IFD_FMT_STR5, 5'h0, {5'h0, 4'(o), 1'b0, 4'h0, 10'h00e});
                chk(32'({dv.match_mode, dv.backward, dv.translate}), 32'(o));
            end
        end
        for (int o = 2; o < 8; o++) begin
            if (o != 4 && o != 5) begin
                dec(IFD_FMT_FLT9, 5'h0, {10'h0, 3'(o), 1'b1, 10'h03e});
                chk(32'({dv.undefined_opcode_trap, dv.long_operand}), 32'h1);
                chk(32'(dv.reg_sel), 32'(o));
                dec(IFD_FMT_FLT9, 5'h0, {10'h0, 3'(o), 1'b0, 10'h03e});
                chk(32'(dv.long_operand), 32'h0);
            end
        end
        foreach (e0[i]) begin
            dec(IFD_FMT_CTRL1, 5'h0, {16'h0, 4'(i == 0 ? 0 : 9 + i / 2), 4'h2});
            chk(32'({dv.undefined_opcode_trap, dv.reg_sel}),
                32'(i == 0 ? 0 : 9 + i / 2));
        end
        for (int o = 0; o < 8; o++) begin
            dec(IFD_FMT_MOV8, 5'h0, {5'h0, 3'(o), 16'h00ce});
            chk(32'(dv.undefined_opcode_trap), 32'(8'hf5 >> o) & 32'h1);
            dec(IFD_FMT_CUST15, 5'h0, {10'h0, 4'(o), 10'h016});
            chk(32'(dv.undefined_opcode_trap), 32'(o > 3));
            dec(IFD_FMT_CUST15, 5'h0, {10'h0, 4'(o), 10'h036});
            chk(32'(dv.undefined_opcode_trap), 32'h1);
        end
        dec(IFD_FMT_STR5, 5'h0, {5'h0, 4'ha, 1'b0, 4'h2, 10'h00e});
        axr(`IFD_OFF_CFG, v, r);
        chk(v, 32'ha);
        axw(`IFD_OFF_MASK, 32'h1 << `IFD_ST_TRAP, r);
        axr(`IFD_OFF_STAT, v, r);
        chk(32'(irq), 32'h0);
        e0 = irq_events;
        dec(IFD_FMT_ONE3, 5'h0, 24'h0000ff);
        chk({31'h0, irq, 24'h0, irq_events}, {32'h1, 24'h0, e0 + 8'h1});
        axr(`IFD_OFF_STAT, v, r);
        chk(v, (32'h1 << `IFD_ST_TRAP) | (32'h1 << `IFD_ST_DONE));
        chk(32'(irq), 32'h0);
        axw(`IFD_OFF_MASK, 32'h0, r);
        dec(IFD_FMT_ONE3, 5'h0, 24'h0000ff);
        chk(32'(irq), 32'h0);
        axw(`IFD_OFF_MASK, 32'h1 << `IFD_ST_DONE, r);
        chk(32'(irq), 32'h1);
        axr(`IFD_OFF_STAT, v, r);
        chk(32'(irq), 32'h0);
        dec(IFD_FMT_NONE, 5'h0, 24'h000000);
        chk(32'(irq), 32'h1);
        finish_test();
    end

    function automatic logic v_sign(input logic [3:0] q);
        return q[3];
    endfunction
endmodule // tb_ifd_decoder
